// File: logic/tsca_sensor_ctrl.sv
module tsca_sensor_ctrl
  import tsca_pkg::*;
#(
  parameter int unsigned CONV10_CYCLES      = CONV10_CYC,
  parameter int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_CYC,
  parameter int unsigned TIMEOUT_CYCLES     = TIMEOUT_CYC,
  parameter logic [6:0]  SLAVE_ADDR         = SLAVE_ADDR_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [16:0] temp_raw_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             overtemp_o,
  output logic             converting_o
);

  tsca_i2c_ev_t ev;
  logic [7:0]   tx_byte;

  // Raw reading synchroniser; samples every clock, result taken only at conversion end
  logic [16:0]  raw_s1_q, raw_s2_q;

  tsca_seq_t    seq_q, seq_d;
  logic [31:0]  per_q, per_d;
  logic [31:0]  conv_q, conv_d;
  logic         os_q, os_d;
  logic         fmt_lat_q, fmt_lat_d;
  logic [1:0]   res_lat_q, res_lat_d;
  logic         act_q, act_d;
  logic [31:0]  per_len, conv_len;
  logic         tick, done, enter_sd, os_req;

  logic [15:0]  cfg_q, cfg_d;
  logic [15:0]  hyst_q, hyst_d;
  logic [15:0]  high_q, high_d;
  logic [15:0]  temp_q, temp_d;
  logic [7:0]   ptr_q, ptr_d;
  logic [7:0]   whi_q, whi_d;
  logic [7:0]   wlo_q, wlo_d;
  logic [2:0]   widx_q, widx_d;
  logic [1:0]   tidx_q, tidx_d;
  logic         pec_ok_q, pec_ok_d;
  logic [7:0]   crc_q, crc_d;
  logic [15:0]  rd_word_q, rd_word_d;
  logic [15:0]  wr_word, new_temp;
  logic         rd_clear;

  logic         ot_q, ot_d;
  logic         arm_hi_q, arm_hi_d;
  logic [2:0]   fc_q, fc_d;
  logic [15:0]  hyst_eff;
  logic         above, below, qualified, ot_live;

  tsca_i2c_slave #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
    .SLAVE_ADDR     (SLAVE_ADDR)
  ) u_i2c (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    // timeout-disable bit gates the bus watchdog
    .timeout_en_i (~cfg_q[CFG_TO]),
    .tx_byte_i    (tx_byte),
    .ev_o         (ev),
    .sda_o        (sda_o),
    .sda_oe_n_o   (sda_oe_n_o)
  );

  // rate code scales the 0.125 s base period
  always_comb begin
    unique case (cfg_q[CFG_RATE_LO +: 2])
      2'h0: per_len = FAST_PERIOD_CYCLES << 5;
      2'h1: per_len = FAST_PERIOD_CYCLES << 3;
      2'h2: per_len = FAST_PERIOD_CYCLES << 1;
      2'h3: per_len = FAST_PERIOD_CYCLES;
    endcase
  end

  // conversion time doubles per bit of resolution up to code 2, and quadruples from code 2 to code 3
  always_comb begin
    unique case (res_lat_q)
      2'h0: conv_len = CONV10_CYCLES >> 2;
      2'h1: conv_len = CONV10_CYCLES >> 1;
      2'h2: conv_len = CONV10_CYCLES;
      2'h3: conv_len = CONV10_CYCLES << 2;
    endcase
  end

  assign tick = (per_q >= per_len - 32'h1);

  always_comb begin
    seq_d     = seq_q;
    per_d     = tick ? '0 : per_q + 32'h1;
    conv_d    = conv_q + 32'h1;
    os_d      = os_q | os_req;
    fmt_lat_d = fmt_lat_q;
    res_lat_d = res_lat_q;
    done      = 1'b0;
    enter_sd  = 1'b0;
    unique case (seq_q)
      SEQ_WAIT: begin
        conv_d = '0;
        if (cfg_q[CFG_SD]) begin
          seq_d    = SEQ_SHUT;
          enter_sd = 1'b1;
        end else if (tick) begin
          seq_d = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (conv_q >= conv_len - 32'h1) begin
          done   = 1'b1;
          conv_d = '0;
          // shutdown taken only once the conversion ends
          if (cfg_q[CFG_SD]) begin
            seq_d    = SEQ_SHUT;
            enter_sd = ~os_q;
          end else begin
            seq_d = SEQ_WAIT;
          end
          // one-shot bit reads zero after completion
          os_d = 1'b0;
        // a period that ends first restarts and drops the result
        end else if (tick && !os_q && !cfg_q[CFG_SD]) begin
          conv_d = '0;
        end
      end
      SEQ_SHUT: begin
        per_d  = '0;
        conv_d = '0;
        // leaving shutdown starts a conversion at once
        if (!cfg_q[CFG_SD] || os_q) begin
          seq_d = SEQ_CONV;
        end
      end
      default: seq_d = SEQ_WAIT;
    endcase
    if (seq_d == SEQ_CONV && conv_d == '0) begin
      // encoding fixed at start, published at completion
      fmt_lat_d = cfg_q[CFG_FMT];
      res_lat_d = cfg_q[CFG_RES_LO +: 2];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      raw_s1_q  <= '0;
      raw_s2_q  <= '0;
      seq_q     <= SEQ_WAIT;
      per_q     <= '0;
      conv_q    <= '0;
      os_q      <= 1'b0;
      fmt_lat_q <= 1'b0;
      res_lat_q <= CFG_RST[CFG_RES_LO +: 2];
      act_q     <= 1'b0;
    end else begin
      raw_s1_q  <= temp_raw_i;
      raw_s2_q  <= raw_s1_q;
      seq_q     <= seq_d;
      per_q     <= per_d;
      conv_q    <= conv_d;
      os_q      <= os_d;
      fmt_lat_q <= fmt_lat_d;
      res_lat_q <= res_lat_d;
      act_q     <= act_d;
    end
  end

  assign act_d = (seq_d == SEQ_CONV);

  // normal saturates to 16 bits, extended halves the scale
  always_comb begin
    if (fmt_lat_q) begin
      new_temp = raw_s2_q[16:1];
    end else if (raw_s2_q[16] != raw_s2_q[15]) begin
      new_temp = raw_s2_q[16] ? TEMP_NEG_SAT : TEMP_POS_SAT;
    end else begin
      new_temp = raw_s2_q[15:0];
    end
    // resolution masks the unused low bits
    new_temp = new_temp & tsca_res_mask(res_lat_q, fmt_lat_q);
  end

  // hysteresis never compares above the high threshold
  assign hyst_eff = ($signed(hyst_q) > $signed(high_q)) ? high_q : hyst_q;
  assign above    = $signed(new_temp) > $signed(high_q);
  assign below    = $signed(new_temp) < $signed(hyst_eff);
  // in interrupt mode a matched read of any register clears the flag
  assign rd_clear = ev.rx_vld & ev.rx_addr & ev.rd & cfg_q[CFG_CI];
  assign ot_live  = ot_q & ~rd_clear;

  always_comb begin
    fc_d     = fc_q;
    ot_d     = ot_live;
    arm_hi_d = arm_hi_q;
    qualified = 1'b0;
    if (done) begin
      fc_d      = above ? ((fc_q == FAULT_MAX) ? FAULT_MAX : fc_q + 3'h1) : '0;
      // fault count threshold from the queue field
      qualified = (fc_d >= tsca_fault_need(cfg_q[CFG_FQ_LO +: 2]));
      if (!cfg_q[CFG_CI]) begin
        // queue only gates the set side
        if (qualified) begin
          ot_d = 1'b1;
        end else if (below) begin
          ot_d = 1'b0;
        end
      end else if (!ot_live) begin
        // events alternate between the two thresholds
        if (arm_hi_q && qualified) begin
          ot_d     = 1'b1;
          arm_hi_d = 1'b0;
        end else if (!arm_hi_q && below) begin
          ot_d     = 1'b1;
          arm_hi_d = 1'b1;
        end
      end
    end
    // shutdown entry clears the flag in both modes, except the return to shutdown after a one-shot conversion
    if (enter_sd) begin
      ot_d     = 1'b0;
      arm_hi_d = 1'b1;
      fc_d     = '0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ot_q     <= 1'b0;
      arm_hi_q <= 1'b1;
      fc_q     <= '0;
    end else begin
      ot_q     <= ot_d;
      arm_hi_q <= arm_hi_d;
      fc_q     <= fc_d;
    end
  end

  // on reads the device sends the check byte after the data
  always_comb begin
    if (cfg_q[CFG_PEC] && tidx_q >= TIDX_PEC) begin
      tx_byte = crc_q;
    end else begin
      tx_byte = tidx_q[0] ? rd_word_q[7:0] : rd_word_q[15:8];
    end
  end

  // A one-byte write zero-fills the low byte; HYST and HIGH writes keep their old low byte
  assign wr_word = (widx_q >= WIDX_LO) ? {whi_q, wlo_q} : {whi_q, 8'h00};

  always_comb begin
    cfg_d     = cfg_q;
    hyst_d    = hyst_q;
    high_d    = high_q;
    // the result register changes only on completion
    temp_d    = done ? new_temp : temp_q;
    ptr_d     = ptr_q;
    whi_d     = whi_q;
    wlo_d     = wlo_q;
    widx_d    = widx_q;
    tidx_d    = tidx_q;
    pec_ok_d  = pec_ok_q;
    crc_d     = crc_q;
    rd_word_d = rd_word_q;
    os_req    = 1'b0;
    if (ev.rx_vld) begin
      // every byte of the message, address included, enters the CRC
      // CRC-8 with polynomial 07h, zero start, MSB first
      crc_d = tsca_crc8(crc_q, ev.data);
      if (ev.rx_addr) begin
        widx_d = '0;
        tidx_d = '0;
        if (ev.rd) begin
          // flag shows in the top bit, one-shot in the bottom
          unique case (ptr_q)
            PTR_TEMP: rd_word_d = temp_q;
            PTR_CFG:  rd_word_d = {ot_q, cfg_q[14:1], os_q};
            PTR_HYST: rd_word_d = hyst_q;
            PTR_HIGH: rd_word_d = high_q;
            default:  rd_word_d = '0;
          endcase
        end
      end else begin
        unique case (widx_q)
          3'h0: ptr_d = ev.data;
          3'h1: whi_d = ev.data;
          3'h2: wlo_d = ev.data;
          3'h3: pec_ok_d = (ev.data == crc_q);
          default: ;
        endcase
        widx_d = (widx_q == WIDX_PEC) ? WIDX_PEC : widx_q + 3'h1;
      end
    end
    if (ev.tx_take) begin
      crc_d  = tsca_crc8(crc_q, ev.data);
      tidx_d = (cfg_q[CFG_PEC] && tidx_q >= TIDX_PEC) ? tidx_q : tidx_q + 2'h1;
    end
    if (ev.stop || ev.abort) begin
      crc_d    = CRC_INIT;
      widx_d   = '0;
      pec_ok_d = 1'b0;
    end
    // on writes the master's check byte must match before commit
    // writes are taken in every sequencer state
    if (ev.stop && widx_q >= WIDX_HI && (!cfg_q[CFG_PEC] || (widx_q == WIDX_PEC && pec_ok_q))) begin
      unique case (ptr_q)
        PTR_CFG: begin
          cfg_d = (wr_word & CFG_WR_MASK) | (cfg_q & ~CFG_WR_MASK);
          // one-shot accepted only while staying in shutdown
          os_req = wr_word[CFG_OS] & wr_word[CFG_SD] & (seq_q == SEQ_SHUT);
        end
        PTR_HYST: hyst_d = (widx_q >= WIDX_LO) ? wr_word : {whi_q, hyst_q[7:0]};
        PTR_HIGH: high_d = (widx_q >= WIDX_LO) ? wr_word : {whi_q, high_q[7:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q     <= CFG_RST;
      hyst_q    <= HYST_RST;
      high_q    <= HIGH_RST;
      temp_q    <= TEMP_RST;
      ptr_q     <= PTR_TEMP;
      whi_q     <= '0;
      wlo_q     <= '0;
      widx_q    <= '0;
      tidx_q    <= '0;
      pec_ok_q  <= 1'b0;
      crc_q     <= CRC_INIT;
      rd_word_q <= '0;
    end else begin
      cfg_q     <= cfg_d;
      hyst_q    <= hyst_d;
      high_q    <= high_d;
      temp_q    <= temp_d;
      ptr_q     <= ptr_d;
      whi_q     <= whi_d;
      wlo_q     <= wlo_d;
      widx_q    <= widx_d;
      tidx_q    <= tidx_d;
      pec_ok_q  <= pec_ok_d;
      crc_q     <= crc_d;
      rd_word_q <= rd_word_d;
    end
  end

  assign overtemp_o   = ot_q;
  assign converting_o = act_q;

endmodule

// File: logic/tsca_pkg.sv
package tsca_pkg;

  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned CONV10_US       = 35000;
  localparam int unsigned CONV10_CYC      = CONV10_US * CLK_MHZ;
  localparam int unsigned FAST_PERIOD_US  = 125000;
  localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_US      = 30000;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_US * CLK_MHZ;

  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h48;

  localparam logic [7:0]  PTR_TEMP = 8'h00;
  localparam logic [7:0]  PTR_CFG  = 8'h01;
  localparam logic [7:0]  PTR_HYST = 8'h02;
  localparam logic [7:0]  PTR_HIGH = 8'h03;

  localparam logic [15:0] TEMP_RST    = 16'h0000;
  localparam logic [15:0] CFG_RST     = 16'h0040;
  localparam logic [15:0] HYST_RST    = 16'h4B00;
  localparam logic [15:0] HIGH_RST    = 16'h5000;
  localparam logic [15:0] CFG_WR_MASK = 16'h1BFE;
  localparam logic [15:0] TEMP_POS_SAT = 16'h7FFF;
  localparam logic [15:0] TEMP_NEG_SAT = 16'h8000;

  localparam int CFG_OT      = 15;
  localparam int CFG_FQ_LO   = 11;
  localparam int CFG_CI      = 9;
  localparam int CFG_SD      = 8;
  localparam int CFG_FMT     = 7;
  localparam int CFG_RES_LO  = 5;
  localparam int CFG_TO      = 4;
  localparam int CFG_PEC     = 3;
  localparam int CFG_RATE_LO = 1;
  localparam int CFG_OS      = 0;

  localparam logic [2:0]  FAULT_MAX = 3'h6;
  localparam logic [7:0]  CRC_POLY  = 8'h07;
  localparam logic [7:0]  CRC_INIT  = 8'h00;
  // Bytes counted after the address byte of a write; TIDX_PEC counts those of a read
  localparam logic [2:0]  WIDX_HI   = 3'h2;
  localparam logic [2:0]  WIDX_LO   = 3'h3;
  localparam logic [2:0]  WIDX_PEC  = 3'h4;
  localparam logic [1:0]  TIDX_PEC  = 2'h2;

  typedef enum logic [1:0] {SEQ_WAIT, SEQ_CONV, SEQ_SHUT} tsca_seq_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_RX, I2C_TX, I2C_MACK} tsca_i2c_st_t;

  typedef struct packed {
    logic       rx_vld;
    logic       rx_addr;
    logic       rd;
    logic       tx_take;
    logic       stop;
    logic       abort;
    logic [7:0] data;
  } tsca_i2c_ev_t;

  function automatic logic [2:0] tsca_fault_need(input logic [1:0] code);
    unique case (code)
      2'h0: return 3'h1;
      2'h1: return 3'h2;
      2'h2: return 3'h4;
      2'h3: return 3'h6;
    endcase
  endfunction

  function automatic logic [15:0] tsca_res_mask(input logic [1:0] res, input logic ext);
    logic [15:0] m;
    unique case (res)
      2'h0: m = 16'hFF00;
      2'h1: m = 16'hFF80;
      2'h2: m = 16'hFFC0;
      2'h3: m = 16'hFFF0;
    endcase
    return ext ? {1'b1, m[15:1]} : m;
  endfunction

  function automatic logic [7:0] tsca_crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : CRC_INIT);
    end
    return c;
  endfunction

endpackage

// File: logic/tsca_i2c_slave.sv
module tsca_i2c_slave
  import tsca_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [6:0]  SLAVE_ADDR     = SLAVE_ADDR_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       timeout_en_i,
  input  wire logic [7:0] tx_byte_i,
  output tsca_i2c_ev_t    ev_o,
  output logic            sda_o,
  output logic            sda_oe_n_o
);

  logic          scl_s1_q, scl_s2_q, scl_s3_q;
  logic          sda_s1_q, sda_s2_q, sda_s3_q;
  tsca_i2c_st_t  st_q, st_d;
  logic [7:0]    sh_q, sh_d;
  logic [2:0]    cnt_q, cnt_d;
  logic          rw_q, rw_d;
  logic          flag_q, flag_d;
  logic          drv_q, drv_d;
  logic [31:0]   to_q, to_d;
  tsca_i2c_ev_t  ev_q, ev_d;
  logic          rise, fall, start, stop, tmo;

  assign rise  = scl_s2_q & ~scl_s3_q;
  assign fall  = ~scl_s2_q & scl_s3_q;
  assign start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign tmo   = (to_q == TIMEOUT_CYCLES - 1);

  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    rw_d   = rw_q;
    flag_d = flag_q;
    drv_d  = drv_q;
    ev_d   = '0;
    // timeout counts only while SCL is held low inside a transfer
    to_d   = (timeout_en_i && st_q != I2C_IDLE && !scl_s2_q) ? to_q + 32'h1 : '0;
    if (start) begin
      st_d   = I2C_ADDR;
      cnt_d  = '0;
      flag_d = 1'b0;
      drv_d  = 1'b1;
    end else if (stop) begin
      st_d    = I2C_IDLE;
      drv_d   = 1'b1;
      ev_d.stop = 1'b1;
    end else if (tmo) begin
      st_d     = I2C_IDLE;
      drv_d    = 1'b1;
      to_d     = '0;
      ev_d.abort = 1'b1;
    end else begin
      unique case (st_q)
        I2C_IDLE: begin
        end
        I2C_ADDR, I2C_RX: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              flag_d      = 1'b1;
              ev_d.rx_vld = 1'b1;
              ev_d.data   = {sh_q[6:0], sda_s2_q};
              if (st_q == I2C_ADDR) begin
                if (sh_q[6:0] == SLAVE_ADDR) begin
                  rw_d         = sda_s2_q;
                  ev_d.rx_addr = 1'b1;
                  ev_d.rd      = sda_s2_q;
                end else begin
                  st_d        = I2C_IDLE;
                  ev_d.rx_vld = 1'b0;
                end
              end
            end
          end else if (fall && flag_q) begin
            drv_d  = 1'b0;
            flag_d = 1'b0;
            st_d   = I2C_ACK;
          end
        end
        I2C_ACK: begin
          if (fall) begin
            cnt_d = '0;
            if (rw_q) begin
              sh_d         = {tx_byte_i[6:0], 1'b0};
              drv_d        = tx_byte_i[7];
              ev_d.tx_take = 1'b1;
              ev_d.data    = tx_byte_i;
              st_d         = I2C_TX;
            end else begin
              drv_d = 1'b1;
              st_d  = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          if (rise) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              flag_d = 1'b1;
            end
          end else if (fall) begin
            if (flag_q) begin
              drv_d  = 1'b1;
              flag_d = 1'b0;
              st_d   = I2C_MACK;
            end else begin
              drv_d = sh_q[7];
              sh_d  = {sh_q[6:0], 1'b0};
            end
          end
        end
        I2C_MACK: begin
          // Master ACK loops back through the load step; NACK ends the read
          if (rise) begin
            st_d = sda_s2_q ? I2C_IDLE : I2C_ACK;
          end
        end
        default: st_d = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      st_q     <= I2C_IDLE;
      sh_q     <= '0;
      cnt_q    <= '0;
      rw_q     <= 1'b0;
      flag_q   <= 1'b0;
      drv_q    <= 1'b1;
      to_q     <= '0;
      ev_q     <= '0;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      st_q     <= st_d;
      sh_q     <= sh_d;
      cnt_q    <= cnt_d;
      rw_q     <= rw_d;
      flag_q   <= flag_d;
      drv_q    <= drv_d;
      to_q     <= to_d;
      ev_q     <= ev_d;
    end
  end

  assign ev_o       = ev_q;
  assign sda_o      = drv_q;
  assign sda_oe_n_o = drv_q;

endmodule

// File: bench/tsca_i2c_master.sv
module tsca_i2c_master
  import tsca_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int naks = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data moves mid-low so it never races the SCL edge
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    w(2);
    scl_o = 1'b1;
    w(2);
    r = sda_i;
    w(2);
    scl_o = 1'b0;
    w(2);
  endtask
  task automatic byte8(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
  endtask
  task automatic xw(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    byte8(b, r);
    bit_io(1'b1, a);
    naks += int'(a);
  endtask
  task automatic start();
    sda_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b0;
    w(2);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b1;
    w(8);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    start();
    xw({SLAVE_ADDR_DEF, 1'b0});
    xw(p);
    xw(d[15:8]);
    xw(d[7:0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic a;
    start();
    xw({SLAVE_ADDR_DEF, 1'b0});
    xw(p);
    start();
    xw({SLAVE_ADDR_DEF, 1'b1});
    byte8(8'hFF, d[15:8]);
    bit_io(1'b0, a);
    byte8(8'hFF, d[7:0]);
    bit_io(1'b1, a);
    stop();
  endtask
  // Three-byte read: ACK after hi and lo, NACK after the check byte
  task automatic rdp(input logic [7:0] p, output logic [23:0] d);
    logic a;
    start();
    xw({SLAVE_ADDR_DEF, 1'b0});
    xw(p);
    start();
    xw({SLAVE_ADDR_DEF, 1'b1});
    for (int i = 2; i >= 0; i--) begin
      byte8(8'hFF, d[i*8 +: 8]);
      bit_io(i == 0, a);
    end
    stop();
  endtask
endmodule

// File: bench/tsca_sensor_ctrl_sva.sv
module tsca_sensor_ctrl_sva
  import tsca_pkg::*;
#(
  parameter int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic overtemp_o,
  input wire logic converting_o
);
  localparam logic [31:0] FIRST = 32'(32 * FAST_PERIOD_CYCLES);
  logic [31:0] up_q, up_d;
  logic [3:0]  hi_q, hi_d;
  always_comb begin
    up_d = (up_q < FIRST) ? up_q + 32'h1 : up_q;
    hi_d = !scl_i ? 4'h0 : (hi_q == 4'hF) ? hi_q : hi_q + 4'h1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_q <= 32'h0;
      hi_q <= 4'h0;
    end else begin
      up_q <= up_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_busy; converting_o [*8]; endsequence
  sequence s_idle; !converting_o [*8]; endsequence
  sequence s_scl_hi; scl_i [*4]; endsequence
  property p_pin; sda_o == sda_oe_n_o; endproperty
  property p_rst; $fell(sys_rst_i) |-> sda_oe_n_o && !overtemp_o && !converting_o; endproperty
  property p_first; converting_o |-> up_q >= FIRST - 32'h4; endproperty
  property p_busy; $rose(converting_o) |-> s_busy; endproperty
  property p_gap; $fell(converting_o) |=> s_idle; endproperty
  property p_flag; $rose(overtemp_o) |-> $past(converting_o) || $past(converting_o, 2); endproperty
  property p_hold; s_scl_hi |-> $stable(sda_oe_n_o); endproperty
  property p_rel; hi_q == 4'hF |-> sda_oe_n_o; endproperty
  a_pin: assert property (p_pin)
    else $error("sda value and enable differ");
  a_rst: assert property (p_rst)
    else $error("outputs busy after reset");
  a_first: assert property (p_first)
    else $error("conversion before first period");
  a_busy: assert property (p_busy)
    else $error("conversion too short");
  a_gap: assert property (p_gap)
    else $error("no idle between conversions");
  a_flag: assert property (p_flag)
    else $error("flag set outside completion");
  a_hold: assert property (p_hold)
    else $error("sda moved during scl high");
  a_rel: assert property (p_rel)
    else $error("sda held on idle bus");
endmodule

bind tsca_sensor_ctrl tsca_sensor_ctrl_sva #(.FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES)) i_tsca_sensor_ctrl_sva (
  .clk_i        (clk_i),
  .sys_rst_i    (sys_rst_i),
  .scl_i        (scl_i),
  .sda_o        (sda_o),
  .sda_oe_n_o   (sda_oe_n_o),
  .overtemp_o   (overtemp_o),
  .converting_o (converting_o)
);

// File: bench/tb.sv
module tb;
  import tsca_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FP = 200;
  localparam int CV = 40;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [16:0] temp = 17'h0;
  logic        scl, sda_m, sda_o, sda_oe_n, ot, conv;
  // Open drain with pull-up
  wire logic   sda_w = sda_m & sda_oe_n;
  int          errors = 0;
  int          cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  tsca_sensor_ctrl #(.CONV10_CYCLES(CV), .FAST_PERIOD_CYCLES(FP), .TIMEOUT_CYCLES(400)) i_tsca_sensor_ctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .temp_raw_i(temp),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .overtemp_o(ot), .converting_o(conv));
  tsca_i2c_master i_tsca_i2c_master (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, s);
    end
  endtask
  task automatic span(input logic v, input int lim, output int n);
    n = 0;
    while (conv === v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Sensor input may only move between conversions
  task automatic done();
    int n;
    span(1'b0, 9000, n);
    span(1'b1, 9000, n);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic t_por();
    logic [15:0] d;
    logic [15:0] e[4] = '{TEMP_RST, CFG_RST, HYST_RST, HIGH_RST};
    for (int p = 0; p < 4; p++) begin
      i_tsca_i2c_master.rd(8'(p), d);
      chk("por", d, e[p]);
    end
    $display("t_por end");
  endtask
  task automatic t_rate();
    int n, len, gap;
    int lens[4] = '{CV / 4, CV / 2, CV, CV * 4};
    int pers[4] = '{32 * FP, 8 * FP, 2 * FP, FP};
    for (int i = 0; i < 4; i++) begin
      i_tsca_i2c_master.wr(PTR_CFG, 16'((i << 5) | (i << 1)));
      span(1'b1, 9000, n);
      span(1'b0, 9000, n);
      span(1'b1, 9000, len);
      span(1'b0, 9000, gap);
      chk("conv len", len, lens[i]);
      chk("period", len + gap, pers[i]);
    end
    $display("t_rate end");
  endtask
  task automatic t_flag();
    logic [15:0] d;
    int n;
    i_tsca_i2c_master.wr(PTR_CFG, 16'h0846);
    done();
    temp = 17'h05A00;
    done();
    chk("ot q1", ot, 1'b0);
    done();
    chk("ot q2", ot, 1'b1);
    temp = 17'h04600;
    done();
    chk("ot low", ot, 1'b0);
    // mode changed only while the flag is clear
    i_tsca_i2c_master.wr(PTR_CFG, 16'h0246);
    done();
    temp = 17'h05A00;
    done();
    chk("ot int", ot, 1'b1);
    i_tsca_i2c_master.rd(PTR_TEMP, d);
    chk("ot rd", ot, 1'b0);
    chk("temp", d, 16'h5A00);
    done();
    chk("ot arm", ot, 1'b0);
    temp = 17'h04600;
    done();
    chk("ot hyst", ot, 1'b1);
    i_tsca_i2c_master.wr(PTR_CFG, 16'h0346);
    span(1'b1, 9000, n);
    repeat (3) @(negedge clk_i);
    chk("ot sd", ot, 1'b0);
    span(1'b0, 600, n);
    chk("sd idle", n, 600);
    $display("t_flag end");
  endtask
  task automatic t_shut();
    logic [15:0] d;
    int n;
    i_tsca_i2c_master.wr(PTR_HYST, 16'h4600);
    i_tsca_i2c_master.rd(PTR_HYST, d);
    chk("hyst", d, 16'h4600);
    i_tsca_i2c_master.wr(PTR_CFG, 16'h0347);
    span(1'b0, 40, n);
    chk("os start", n < 40, 1'b1);
    span(1'b1, 9000, n);
    i_tsca_i2c_master.rd(PTR_CFG, d);
    chk("os cfg", d, 16'h0346);
    span(1'b0, 600, n);
    chk("os idle", n, 600);
    i_tsca_i2c_master.wr(PTR_CFG, 16'h0246);
    span(1'b0, 40, n);
    chk("wake", n < 40, 1'b1);
    done();
    temp = 17'h09600;
    i_tsca_i2c_master.wr(PTR_CFG, 16'h02C6);
    done();
    done();
    i_tsca_i2c_master.rd(PTR_TEMP, d);
    chk("ext", d, 16'h4B00);
    $display("t_shut end");
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return r;
  endfunction
  task automatic t_pec();
    logic [23:0] d;
    logic [7:0]  c;
    // SCL held low drops the partial write
    i_tsca_i2c_master.start();
    i_tsca_i2c_master.xw({SLAVE_ADDR_DEF, 1'b0});
    i_tsca_i2c_master.xw(PTR_HIGH);
    i_tsca_i2c_master.xw(8'h60);
    repeat (500) @(negedge clk_i);
    i_tsca_i2c_master.stop();
    i_tsca_i2c_master.wr(PTR_CFG, 16'h02CE);
    // write without its check byte is refused
    i_tsca_i2c_master.wr(PTR_HIGH, 16'h7000);
    i_tsca_i2c_master.rdp(PTR_HIGH, d);
    c = crc(crc(crc(8'h00, {SLAVE_ADDR_DEF, 1'b0}), PTR_HIGH), {SLAVE_ADDR_DEF, 1'b1});
    c = crc(crc(c, HIGH_RST[15:8]), HIGH_RST[7:0]);
    chk("pec", d, {HIGH_RST, c});
    $display("t_pec end");
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_por();
    t_rate();
    t_flag();
    t_shut();
    t_pec();
    chk("acks", i_tsca_i2c_master.naks, 0);
    end_of_test();
  end
  initial begin
    repeat (90000) @(negedge clk_i);
    errors++;
    end_of_test();
  end
endmodule
